// *** src/vsrk_defines.svh ***
// Offsets, field positions, reset values and counts of the valve supervisor.
// Assumes percent values are scaled so that 10000 counts are 100 percent.
`ifndef VSRK_DEFINES_SVH
`define VSRK_DEFINES_SVH
`define VSRK_A_CTRL 8'h00
`define VSRK_A_STATE 8'h04
`define VSRK_A_TSO_THR 8'h08
`define VSRK_A_TSO_DB 8'h0C
`define VSRK_A_DEV_LIM 8'h10
`define VSRK_A_POS_LIM 8'h14
`define VSRK_A_ALRT_LO 8'h18
`define VSRK_A_ALRT_HI 8'h1C
`define VSRK_A_ALRT_CFG 8'h20
`define VSRK_A_INT_STAT 8'h24
`define VSRK_A_INT_MASK 8'h28
`define VSRK_A_HIST_SEL 8'h2C
`define VSRK_A_HIST_DATA 8'h30
`define VSRK_A_CUR_KPI 8'h34
`define VSRK_A_TSO_CNT 8'h38
`define VSRK_RESP_OK 2'h0
`define VSRK_RESP_ERR 2'h2
`define VSRK_CTRL_RST 9'h000
`define VSRK_TSO_THR_RST 16'h00C8
`define VSRK_TSO_DB_RST 16'h0032
`define VSRK_LIM_RST 16'h01F4
`define VSRK_POS_LIM_RST 16'h2774
`define VSRK_ALRT_HI_RST 16'hFFFF
`define VSRK_CTRL_RET 8
`define VSRK_DIAG_ADV 2'h2
`define VSRK_MOVE_LIM 16'h00C8
`define VSRK_MIN_PER_HR 6'h3C
`define VSRK_HR_PER_DAY 5'h18
`define VSRK_DAY_PER_WK 3'h7
`define VSRK_WEEKS 6'h34
`define VSRK_I_TSO 0
`define VSRK_I_FB_IN 1
`define VSRK_I_FB_OUT 2
`define VSRK_I_FB_ABORT 3
`define VSRK_I_ALERT 4
`define VSRK_I_HOUR 5
`define VSRK_NINT 6
`endif

// *** src/vsrk_pkg.sv ***
// Types shared by the valve supervisor: configuration, pressures and states.
// Assumes the defines header is compiled alongside.
package vsrk_pkg;
	typedef struct packed {
		logic [15:0] supply;
		logic [15:0] signal;
		logic [15:0] actuator;
	} vsrk_press_t;
	typedef struct packed {
		logic ret_req;
		logic tso_en;
		logic [1:0] diag;
		logic auto_ret;
		logic trig_fail;
		logic trig_dev;
		logic trig_lim;
		logic fb_en;
	} vsrk_ctrl_t;
	typedef enum logic [1:0] {VSRK_NORMAL, VSRK_FB, VSRK_FB_WAIT} vsrk_state_t;
endpackage

// *** src/vsrk_top.sv ***
// Valve supervisor: tight shutoff, pressure-inferred fallback, indicator history and alerts.
// Assumes a one-minute tick pulse, synchronous sensor inputs and an AXI4-Lite master.
`timescale 1ns/100ps
`include "vsrk_defines.svh"

module vsrk_top import vsrk_pkg::*; (
	// Clock and reset.
	input wire logic clock,
	input wire logic resetn,
	// AXI4-Lite slave.
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// Valve sensors and time base.
	input wire logic minute_tick,
	input wire logic [15:0] setpoint,
	input wire logic [15:0] position,
	input wire logic sensor_fail,
	input wire vsrk_press_t press,
	input wire logic low_supply_fault,
	input wire logic marginal_power,
	input wire logic signature_done,
	input wire logic [15:0] kpi_sample,
	// Actuator drive and alerts.
	output logic full_thrust,
	output logic fb_active,
	output logic [15:0] loop_position,
	output logic alert_publish,
	output logic irq
);
	function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
		absdiff = (a > b) ? a - b : b - a;
	endfunction

	// ****************************************
	// Register bus
	// ****************************************
	logic awready_r, awready_nxt, wready_r, wready_nxt, aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
	logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [7:0] waddr_r, waddr_nxt;
	logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
	logic wr_en, rd_en, wr_hit, rd_hit, lim_touch, wstb_r, wstb_nxt;
	vsrk_ctrl_t ctrl_r, ctrl_nxt;
	logic [15:0] tso_thr_r, tso_thr_nxt, tso_db_r, tso_db_nxt, dev_lim_r, dev_lim_nxt;
	logic [15:0] pos_lim_r, pos_lim_nxt, alo_r, alo_nxt, ahi_r, ahi_nxt;
	logic [1:0] acfg_r, acfg_nxt;
	logic [`VSRK_NINT-1:0] ist_r, ist_nxt, imask_r, imask_nxt, ev;
	logic [7:0] hsel_r, hsel_nxt;
	logic [15:0] tso_cnt_r, tso_cnt_nxt;
	logic [31:0] rmux;
	vsrk_state_t st_r, st_nxt;
	logic tso_r, tso_nxt, ret_pend_r, ret_pend_nxt;
	logic [15:0] hr_store [24];
	logic [15:0] dy_store [7];
	logic [15:0] wk_store [52];
	logic [4:0] hr_ptr_r, hr_ptr_nxt;
	logic [2:0] dy_ptr_r, dy_ptr_nxt;
	logic [5:0] wk_ptr_r, wk_ptr_nxt;
	logic [15:0] hist_rd, hr_last_r, hr_last_nxt;

	always_comb begin
		hist_rd = 16'h0000;
		case (hsel_r[7:6])
			2'h0: if (hsel_r[4:0] < `VSRK_HR_PER_DAY) hist_rd = hr_store[hsel_r[4:0]];
			2'h1: if (hsel_r[2:0] < `VSRK_DAY_PER_WK) hist_rd = dy_store[hsel_r[2:0]];
			default: if (hsel_r[5:0] < `VSRK_WEEKS) hist_rd = wk_store[hsel_r[5:0]];
		endcase
	end

	always_comb begin
		wr_en = aw_got_r && w_got_r && !bvalid_r;
		rd_en = s_axi_arvalid && arready_r;
		rd_hit = 1'b1;
		case (s_axi_araddr)
			`VSRK_A_CTRL: rmux = {23'h0, 1'b0, ctrl_r[7:0]};
			`VSRK_A_STATE: rmux = {8'h0, wk_ptr_r, dy_ptr_r, hr_ptr_r, 6'h0, tso_r, ret_pend_r, 2'(st_r)};
			`VSRK_A_TSO_THR: rmux = {16'h0, tso_thr_r};
			`VSRK_A_TSO_DB: rmux = {16'h0, tso_db_r};
			`VSRK_A_DEV_LIM: rmux = {16'h0, dev_lim_r};
			`VSRK_A_POS_LIM: rmux = {16'h0, pos_lim_r};
			`VSRK_A_ALRT_LO: rmux = {16'h0, alo_r};
			`VSRK_A_ALRT_HI: rmux = {16'h0, ahi_r};
			`VSRK_A_ALRT_CFG: rmux = {29'h0, alert_publish, acfg_r};
			`VSRK_A_INT_STAT: rmux = {26'h0, ist_r};
			`VSRK_A_INT_MASK: rmux = {26'h0, imask_r};
			`VSRK_A_HIST_SEL: rmux = {24'h0, hsel_r};
			`VSRK_A_HIST_DATA: rmux = {16'h0, hist_rd};
			`VSRK_A_CUR_KPI: rmux = {16'h0, kpi_sample};
			`VSRK_A_TSO_CNT: rmux = {16'h0, tso_cnt_r};
			default: begin
				rmux = 32'h0000_0000;
				rd_hit = 1'b0;
			end
		endcase
		case (waddr_r)
			`VSRK_A_CTRL, `VSRK_A_TSO_THR, `VSRK_A_TSO_DB, `VSRK_A_DEV_LIM, `VSRK_A_POS_LIM,
			`VSRK_A_ALRT_LO, `VSRK_A_ALRT_HI, `VSRK_A_ALRT_CFG, `VSRK_A_INT_STAT,
			`VSRK_A_INT_MASK, `VSRK_A_HIST_SEL: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
		lim_touch = (wr_en && (waddr_r == `VSRK_A_ALRT_LO || waddr_r == `VSRK_A_ALRT_HI)) ||
			(rd_en && (s_axi_araddr == `VSRK_A_ALRT_LO || s_axi_araddr == `VSRK_A_ALRT_HI));
		awready_nxt = s_axi_awvalid && !aw_got_r && !awready_r;
		wready_nxt = s_axi_wvalid && !w_got_r && !wready_r;
		aw_got_nxt = (aw_got_r || (s_axi_awvalid && awready_r)) && !wr_en;
		w_got_nxt = (w_got_r || (s_axi_wvalid && wready_r)) && !wr_en;
		waddr_nxt = (s_axi_awvalid && awready_r) ? s_axi_awaddr : waddr_r;
		wdata_nxt = (s_axi_wvalid && wready_r) ? s_axi_wdata : wdata_r;
		wstb_nxt = (s_axi_wvalid && wready_r) ? s_axi_wstrb[0] : wstb_r;
		bvalid_nxt = wr_en || (bvalid_r && !s_axi_bready);
		bresp_nxt = wr_en ? (wr_hit ? `VSRK_RESP_OK : `VSRK_RESP_ERR) : bresp_r;
		arready_nxt = s_axi_arvalid && !arready_r && !rvalid_r;
		rvalid_nxt = rd_en || (rvalid_r && !s_axi_rready);
		rdata_nxt = rd_en ? rmux : rdata_r;
		rresp_nxt = rd_en ? (rd_hit ? `VSRK_RESP_OK : `VSRK_RESP_ERR) : rresp_r;
		ctrl_nxt = ctrl_r;
		ctrl_nxt.ret_req = 1'b0;
		tso_thr_nxt = tso_thr_r;
		tso_db_nxt = tso_db_r;
		dev_lim_nxt = dev_lim_r;
		pos_lim_nxt = pos_lim_r;
		alo_nxt = alo_r;
		ahi_nxt = ahi_r;
		acfg_nxt = acfg_r;
		imask_nxt = imask_r;
		hsel_nxt = hsel_r;
		ist_nxt = ist_r;
		if (wr_en && wstb_r) begin
			case (waddr_r)
				`VSRK_A_CTRL: ctrl_nxt = wdata_r[`VSRK_CTRL_RET:0];
				`VSRK_A_TSO_THR: tso_thr_nxt = wdata_r[15:0];
				`VSRK_A_TSO_DB: tso_db_nxt = wdata_r[15:0];
				`VSRK_A_DEV_LIM: dev_lim_nxt = wdata_r[15:0];
				`VSRK_A_POS_LIM: pos_lim_nxt = wdata_r[15:0];
				`VSRK_A_ALRT_LO: alo_nxt = wdata_r[15:0];
				`VSRK_A_ALRT_HI: ahi_nxt = wdata_r[15:0];
				`VSRK_A_ALRT_CFG: acfg_nxt = wdata_r[1:0];
				`VSRK_A_INT_STAT: ist_nxt = ist_r & ~wdata_r[`VSRK_NINT-1:0];
				`VSRK_A_INT_MASK: imask_nxt = wdata_r[`VSRK_NINT-1:0];
				`VSRK_A_HIST_SEL: hsel_nxt = wdata_r[7:0];
				default: ;
			endcase
		end
		// Setting after clearing lets an event in the clearing cycle survive.
		ist_nxt = ist_nxt | ev;
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			bvalid_r <= 1'b0;
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			bresp_r <= `VSRK_RESP_OK;
			rresp_r <= `VSRK_RESP_OK;
			waddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstb_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			ctrl_r <= `VSRK_CTRL_RST;
			tso_thr_r <= `VSRK_TSO_THR_RST;
			tso_db_r <= `VSRK_TSO_DB_RST;
			dev_lim_r <= `VSRK_LIM_RST;
			pos_lim_r <= `VSRK_POS_LIM_RST;
			alo_r <= 16'h0000;
			ahi_r <= `VSRK_ALRT_HI_RST;
			acfg_r <= 2'h0;
			ist_r <= '0;
			imask_r <= '0;
			hsel_r <= 8'h00;
		end else begin
			awready_r <= awready_nxt;
			wready_r <= wready_nxt;
			aw_got_r <= aw_got_nxt;
			w_got_r <= w_got_nxt;
			bvalid_r <= bvalid_nxt;
			arready_r <= arready_nxt;
			rvalid_r <= rvalid_nxt;
			bresp_r <= bresp_nxt;
			rresp_r <= rresp_nxt;
			waddr_r <= waddr_nxt;
			wdata_r <= wdata_nxt;
			wstb_r <= wstb_nxt;
			rdata_r <= rdata_nxt;
			ctrl_r <= ctrl_nxt;
			tso_thr_r <= tso_thr_nxt;
			tso_db_r <= tso_db_nxt;
			dev_lim_r <= dev_lim_nxt;
			pos_lim_r <= pos_lim_nxt;
			alo_r <= alo_nxt;
			ahi_r <= ahi_nxt;
			acfg_r <= acfg_nxt;
			ist_r <= ist_nxt;
			imask_r <= imask_nxt;
			hsel_r <= hsel_nxt;
		end
	end

	// ****************************************
	// Shutoff and fallback control
	// ****************************************
	logic pre_ok, fault, thrust_nxt, fb_nxt, irq_nxt, alert_pub_nxt;
	logic [15:0] sp_ref_r, sp_ref_nxt, est, lpos_nxt;
	logic [16:0] tso_exit;
	logic [3:0] ctl_ev;

	always_comb begin
		tso_exit = {1'b0, tso_thr_r} + {1'b0, tso_db_r};
		tso_nxt = tso_r;
		tso_cnt_nxt = tso_cnt_r;
		ctl_ev = '0;
		if (!ctrl_r.tso_en) begin
			tso_nxt = 1'b0;
		end else if (!tso_r && setpoint < tso_thr_r) begin
			tso_nxt = 1'b1;
		end else if (tso_r && {1'b0, setpoint} > tso_exit) begin
			tso_nxt = 1'b0;
			tso_cnt_nxt = tso_cnt_r + 16'h0001;
			ctl_ev[`VSRK_I_TSO] = 1'b1;
		end
		pre_ok = ctrl_r.diag >= `VSRK_DIAG_ADV && ctrl_r.fb_en && !low_supply_fault && !marginal_power;
		fault = (ctrl_r.trig_lim && position > pos_lim_r) ||
			(ctrl_r.trig_dev && absdiff(setpoint, position) > dev_lim_r) ||
			(ctrl_r.trig_fail && sensor_fail);
		st_nxt = st_r;
		sp_ref_nxt = sp_ref_r;
		ret_pend_nxt = ret_pend_r || ctrl_r.ret_req;
		case (st_r)
			VSRK_NORMAL: begin
				ret_pend_nxt = 1'b0;
				if (pre_ok && fault) begin
					st_nxt = VSRK_FB;
					ctl_ev[`VSRK_I_FB_IN] = 1'b1;
				end
			end
			VSRK_FB, VSRK_FB_WAIT: begin
				if (!pre_ok) begin
					st_nxt = VSRK_NORMAL;
					ctl_ev[`VSRK_I_FB_ABORT] = 1'b1;
				end else if (fault) begin
					st_nxt = VSRK_FB;
				end else if (st_r == VSRK_FB) begin
					st_nxt = VSRK_FB_WAIT;
					sp_ref_nxt = setpoint;
				end else if (absdiff(setpoint, sp_ref_r) > `VSRK_MOVE_LIM && (ctrl_r.auto_ret || ret_pend_r)) begin
					st_nxt = VSRK_NORMAL;
					ctl_ev[`VSRK_I_FB_OUT] = 1'b1;
				end
			end
			default: st_nxt = VSRK_NORMAL;
		endcase
		// A crude inference; the loop only needs a monotonic travel estimate.
		est = 16'((({1'b0, press.actuator} + {1'b0, press.signal}) >> 1) - (press.supply >> 4));
		fb_nxt = st_nxt != VSRK_NORMAL;
		lpos_nxt = fb_nxt ? est : position;
		thrust_nxt = tso_nxt;
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			tso_r <= 1'b0;
			tso_cnt_r <= 16'h0000;
			st_r <= VSRK_NORMAL;
			sp_ref_r <= 16'h0000;
			ret_pend_r <= 1'b0;
			full_thrust <= 1'b0;
			fb_active <= 1'b0;
			loop_position <= 16'h0000;
		end else begin
			tso_r <= tso_nxt;
			tso_cnt_r <= tso_cnt_nxt;
			st_r <= st_nxt;
			sp_ref_r <= sp_ref_nxt;
			ret_pend_r <= ret_pend_nxt;
			full_thrust <= thrust_nxt;
			fb_active <= fb_nxt;
			loop_position <= lpos_nxt;
		end
	end

	// ****************************************
	// Indicator history and alert
	// ****************************************
	logic [5:0] min_cnt_r, min_cnt_nxt;
	logic [4:0] hr_cnt_r, hr_cnt_nxt;
	logic [2:0] dy_cnt_r, dy_cnt_nxt;
	logic [21:0] msum_r, msum_nxt, msum_in;
	logic [20:0] hsum_r, hsum_nxt, hsum_in;
	logic [18:0] dsum_r, dsum_nxt, dsum_in;
	logic hr_we, dy_we, wk_we, cmp, alert_r, alert_nxt;
	logic [15:0] hr_val, dy_val, wk_val;

	always_comb begin
		msum_in = msum_r + 22'(kpi_sample);
		hr_we = minute_tick && min_cnt_r == `VSRK_MIN_PER_HR - 6'h01;
		hr_val = 16'(msum_in / 22'(`VSRK_MIN_PER_HR));
		hsum_in = hsum_r + 21'(hr_val);
		dy_we = hr_we && hr_cnt_r == `VSRK_HR_PER_DAY - 5'h01;
		dy_val = 16'(hsum_in / 21'(`VSRK_HR_PER_DAY));
		dsum_in = dsum_r + 19'(dy_val);
		wk_we = dy_we && dy_cnt_r == `VSRK_DAY_PER_WK - 3'h1;
		wk_val = 16'(dsum_in / 19'(`VSRK_DAY_PER_WK));
		min_cnt_nxt = minute_tick ? (hr_we ? 6'h00 : min_cnt_r + 6'h01) : min_cnt_r;
		msum_nxt = minute_tick ? (hr_we ? 22'h0 : msum_in) : msum_r;
		hr_cnt_nxt = hr_we ? (dy_we ? 5'h00 : hr_cnt_r + 5'h01) : hr_cnt_r;
		hsum_nxt = hr_we ? (dy_we ? 21'h0 : hsum_in) : hsum_r;
		dy_cnt_nxt = dy_we ? (wk_we ? 3'h0 : dy_cnt_r + 3'h1) : dy_cnt_r;
		dsum_nxt = dy_we ? (wk_we ? 19'h0 : dsum_in) : dsum_r;
		// Pointers wrap, so once 24 hours, 7 days or 52 weeks are stored, each new record overwrites the oldest of its store.
		hr_ptr_nxt = hr_we ? (hr_ptr_r == `VSRK_HR_PER_DAY - 5'h01 ? 5'h00 : hr_ptr_r + 5'h01) : hr_ptr_r;
		dy_ptr_nxt = dy_we ? (dy_ptr_r == `VSRK_DAY_PER_WK - 3'h1 ? 3'h0 : dy_ptr_r + 3'h1) : dy_ptr_r;
		wk_ptr_nxt = wk_we ? (wk_ptr_r == `VSRK_WEEKS - 6'h01 ? 6'h00 : wk_ptr_r + 6'h01) : wk_ptr_r;
		hr_last_nxt = hr_we ? hr_val : hr_last_r;
		cmp = hr_we || lim_touch || signature_done;
		alert_nxt = cmp ? (acfg_r[0] && (hr_last_nxt < alo_nxt || hr_last_nxt > ahi_nxt)) : alert_r;
		alert_pub_nxt = alert_nxt && !acfg_r[1];
		ev = {hr_we, alert_nxt && !alert_r, ctl_ev};
		irq_nxt = |(ist_nxt & imask_nxt);
	end

	always_ff @(posedge clock) begin
		if (hr_we) hr_store[hr_ptr_r] <= hr_val;
		if (dy_we) dy_store[dy_ptr_r] <= dy_val;
		if (wk_we) wk_store[wk_ptr_r] <= wk_val;
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			min_cnt_r <= 6'h00;
			hr_cnt_r <= 5'h00;
			dy_cnt_r <= 3'h0;
			msum_r <= 22'h0;
			hsum_r <= 21'h0;
			dsum_r <= 19'h0;
			hr_ptr_r <= 5'h00;
			dy_ptr_r <= 3'h0;
			wk_ptr_r <= 6'h00;
			hr_last_r <= 16'h0000;
			alert_r <= 1'b0;
			alert_publish <= 1'b0;
			irq <= 1'b0;
		end else begin
			min_cnt_r <= min_cnt_nxt;
			hr_cnt_r <= hr_cnt_nxt;
			dy_cnt_r <= dy_cnt_nxt;
			msum_r <= msum_nxt;
			hsum_r <= hsum_nxt;
			dsum_r <= dsum_nxt;
			hr_ptr_r <= hr_ptr_nxt;
			dy_ptr_r <= dy_ptr_nxt;
			wk_ptr_r <= wk_ptr_nxt;
			hr_last_r <= hr_last_nxt;
			alert_r <= alert_nxt;
			alert_publish <= alert_pub_nxt;
			irq <= irq_nxt;
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
endmodule

// *** dv/vsrk_monitor.sv ***
// Checker of the valve supervisor ports: shutoff, fallback and bus answers.
// Assumes the reset values of shutoff threshold and deadband stay in force.
`timescale 1ns/100ps
`include "vsrk_defines.svh"
module vsrk_monitor import vsrk_pkg::*; (
	// Clock and reset.
	input wire logic clock,
	input wire logic resetn,
	// Bus read side.
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	// Valve side.
	input wire logic [15:0] setpoint,
	input wire logic [15:0] position,
	input wire logic sensor_fail,
	input wire vsrk_press_t press,
	input wire logic low_supply_fault,
	input wire logic marginal_power,
	input wire logic full_thrust,
	input wire logic fb_active,
	input wire logic [15:0] loop_position
);
	// ****
	// Assertions.
	// ****
	function automatic logic [15:0] est(vsrk_press_t p);
		logic [16:0] s;
		s = {1'h0, p.actuator} + {1'h0, p.signal};
		return s[16:1] - {4'h0, p.supply[15:4]};
	endfunction
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	tso_enter_a: assert property ($rose(full_thrust) |-> $past(setpoint) < `VSRK_TSO_THR_RST)
		else $error("shutoff entered at or above threshold");
	tso_hold_a: assert property (full_thrust && setpoint <= `VSRK_TSO_THR_RST + `VSRK_TSO_DB_RST |=> full_thrust)
		else $error("shutoff left inside deadband");
	fb_pre_a: assert property ($rose(fb_active) |-> !$past(low_supply_fault) && !$past(marginal_power))
		else $error("fallback entered without preconditions");
	fb_drop_a: assert property (fb_active && (low_supply_fault || marginal_power) |=> !fb_active)
		else $error("fallback kept after precondition lost");
	fb_hold_a: assert property (fb_active && sensor_fail && !low_supply_fault && !marginal_power |=> fb_active)
		else $error("fallback left while sensor failed");
	fb_est_a: assert property (fb_active && $past(fb_active) && $stable(press) |-> loop_position == est(press))
		else $error("fallback loop position not inferred");
	norm_pos_a: assert property (!fb_active && !$past(fb_active) && $past(resetn) && $stable(position)
		|-> loop_position == position)
		else $error("normal loop position not sensor");
	read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
endmodule
bind vsrk_top vsrk_monitor mon (.clock, .resetn, .s_axi_arready, .s_axi_rvalid, .setpoint, .position,
	.sensor_fail, .press, .low_supply_fault, .marginal_power, .full_thrust, .fb_active, .loop_position);

// *** dv/vsrk_valve_model.sv ***
// Far-side model: minute time base, pressure sensors and indicator source.
// Assumes the bench gates the minute ticks and supplies the indicator value.
`timescale 1ns/100ps
module vsrk_valve_model import vsrk_pkg::*; (
	// Bench control.
	input wire logic clock,
	input wire logic tick_en,
	input wire logic [15:0] kpi_in,
	// Sensor side.
	output logic minute_tick,
	output vsrk_press_t press,
	output logic [15:0] kpi_sample
);
	logic [1:0] div_r = 2'h0;
	logic tick_r = 1'h0;
	// A minute lasts four clocks here so that a simulated week stays short.
	always @(posedge clock) begin
		div_r <= div_r + 2'h1;
		tick_r <= tick_en && div_r == 2'h3;
	end
	assign minute_tick = tick_r;
	assign kpi_sample = kpi_in;
	assign press = '{16'h1000, 16'h3000, 16'h5000};
endmodule

// *** dv/tb_valve_shutoff_recovery_kpi.sv ***
// Bench of the valve supervisor: registers, shutoff, fallback, history and alerts.
// Assumes the far-side model paces one minute every four clocks.
`timescale 1ns/100ps
`include "vsrk_defines.svh"
`define CHK(nm, e, a) begin compares++; if ((a) !== (e)) begin err_count++; \
	$display("mismatch %s exp %0h got %0h", nm, e, a); end end
module tb_valve_shutoff_recovery_kpi;
	import vsrk_pkg::*;
	typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} vsrk_row_t;
	logic clock = 1'h0, resetn = 1'h0, tick_en = 1'h0, signature_done = 1'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, minute_tick;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [15:0] setpoint = 16'h1388, position = 16'h1388, kpi_in = 16'h04D2, loop_position, kpi_sample;
	logic sensor_fail = 1'h0, low_supply_fault = 1'h0, marginal_power = 1'h0;
	logic full_thrust, fb_active, alert_publish, irq;
	vsrk_press_t press;
	int err_count = 0, compares = 0;
	logic [31:0] blk [4] = '{32'hA9, 32'hC9, 32'hC9, 32'hC8};
	vsrk_row_t rows [11] = '{'{1'h0, `VSRK_A_CTRL, 32'h0, 32'h0, `VSRK_RESP_OK},
		'{1'h0, `VSRK_A_TSO_THR, 32'h0, {16'h0, `VSRK_TSO_THR_RST}, `VSRK_RESP_OK},
		'{1'h0, `VSRK_A_TSO_DB, 32'h0, {16'h0, `VSRK_TSO_DB_RST}, `VSRK_RESP_OK},
		'{1'h0, `VSRK_A_DEV_LIM, 32'h0, {16'h0, `VSRK_LIM_RST}, `VSRK_RESP_OK},
		'{1'h0, `VSRK_A_POS_LIM, 32'h0, {16'h0, `VSRK_POS_LIM_RST}, `VSRK_RESP_OK},
		'{1'h0, `VSRK_A_ALRT_HI, 32'h0, {16'h0, `VSRK_ALRT_HI_RST}, `VSRK_RESP_OK},
		'{1'h0, `VSRK_A_ALRT_LO, 32'h0, 32'h0, `VSRK_RESP_OK},
		'{1'h0, 8'h3C, 32'h0, 32'h0, `VSRK_RESP_ERR},
		'{1'h1, 8'h3C, 32'h1, 32'h0, `VSRK_RESP_ERR},
		'{1'h1, `VSRK_A_INT_MASK, 32'h3F, 32'h0, `VSRK_RESP_OK},
		'{1'h0, `VSRK_A_INT_MASK, 32'h0, 32'h3F, `VSRK_RESP_OK}};
	always #5 clock = ~clock;
	vsrk_top uut (.clock, .resetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
		.s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .minute_tick, .setpoint,
		.position, .sensor_fail, .press, .low_supply_fault, .marginal_power, .signature_done, .kpi_sample,
		.full_thrust, .fb_active, .loop_position, .alert_publish, .irq);
	vsrk_valve_model far (.clock, .tick_en, .kpi_in, .minute_tick, .press, .kpi_sample);
	// ****
	// Bus and check tasks.
	// ****
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask
	// Ready is held from the start so the answer is taken at the first edge it shows.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= wr;
		s_axi_wvalid <= wr;
		s_axi_bready <= wr;
		s_axi_arvalid <= !wr;
		s_axi_rready <= !wr;
		while (n < 100) begin
			@(posedge clock);
			n++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_bready && s_axi_bvalid) begin
				s_axi_bready <= 1'h0;
				rsp = s_axi_bresp;
				n = 200;
			end
			if (s_axi_rready && s_axi_rvalid) begin
				s_axi_rready <= 1'h0;
				rsp = s_axi_rresp;
				rd = s_axi_rdata;
				n = 200;
			end
		end
		if (n < 200) `CHK("bus answer", 1'h1, 1'h0)
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'h0, a, 32'h0);
		`CHK($sformatf("register %h", a), e, rd)
	endtask
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// ****
	// Scenarios.
	// ****
	initial begin
		repeat (80000) @(posedge clock);
		err_count++;
		tally_and_finish;
	end
	initial begin
		cyc(20);
		`CHK("outputs in reset", 20'h0, {full_thrust, fb_active, alert_publish, irq, loop_position})
		resetn <= 1'h1;
		foreach (rows[i]) begin
			bus(rows[i].wr, rows[i].a, rows[i].d);
			`CHK("response", rows[i].r, rsp)
			if (!rows[i].wr) `CHK("read data", rows[i].e, rd)
		end
		bus(1'h1, `VSRK_A_CTRL, 32'h80);
		setpoint <= `VSRK_TSO_THR_RST;
		cyc(3);
		`CHK("thrust at threshold", 1'h0, full_thrust)
		setpoint <= `VSRK_TSO_THR_RST - 16'h1;
		cyc(3);
		`CHK("thrust below threshold", 1'h1, full_thrust)
		setpoint <= `VSRK_TSO_THR_RST + `VSRK_TSO_DB_RST;
		cyc(3);
		`CHK("thrust in deadband", 1'h1, full_thrust)
		setpoint <= `VSRK_TSO_THR_RST + `VSRK_TSO_DB_RST + 16'h1;
		cyc(3);
		`CHK("thrust released", 1'h0, full_thrust)
		rchk(`VSRK_A_TSO_CNT, 32'h1);
		bus(1'h1, `VSRK_A_INT_MASK, 32'h0);
		cyc(2);
		`CHK("irq masked", 1'h0, irq)
		bus(1'h1, `VSRK_A_INT_MASK, 32'h3F);
		cyc(2);
		`CHK("irq raised", 1'h1, irq)
		bus(1'h1, `VSRK_A_INT_STAT, 32'h1);
		cyc(2);
		`CHK("irq cleared", 1'h0, irq)
		setpoint <= 16'h1388;
		for (int i = 0; i < 4; i++) begin
			bus(1'h1, `VSRK_A_CTRL, blk[i]);
			low_supply_fault <= i == 1;
			marginal_power <= i == 2;
			sensor_fail <= 1'h1;
			cyc(4);
			`CHK("fallback blocked", 1'h0, fb_active)
			low_supply_fault <= 1'h0;
			marginal_power <= 1'h0;
			sensor_fail <= 1'h0;
		end
		bus(1'h1, `VSRK_A_CTRL, 32'hC9);
		sensor_fail <= 1'h1;
		cyc(4);
		`CHK("fallback entered", 1'h1, fb_active)
		`CHK("inferred position", (16'h5000 + 16'h3000) / 16'h2 - 16'h1000 / 16'h10, loop_position)
		rchk(`VSRK_A_STATE, 32'h1);
		sensor_fail <= 1'h0;
		cyc(3);
		setpoint <= 16'h1388 + `VSRK_MOVE_LIM;
		cyc(4);
		`CHK("fallback kept at limit", 1'h1, fb_active)
		setpoint <= 16'h1388 + `VSRK_MOVE_LIM + 16'h1;
		cyc(4);
		`CHK("fallback awaits request", 1'h1, fb_active)
		bus(1'h1, `VSRK_A_CTRL, 32'h1C9);
		cyc(3);
		`CHK("fallback returned", 1'h0, fb_active)
		rchk(`VSRK_A_INT_STAT, 32'h6);
		bus(1'h1, `VSRK_A_INT_STAT, 32'h3F);
		bus(1'h1, `VSRK_A_CTRL, 32'hD9);
		sensor_fail <= 1'h1;
		cyc(4);
		sensor_fail <= 1'h0;
		cyc(3);
		setpoint <= 16'h1388;
		cyc(4);
		`CHK("fallback auto return", 1'h0, fb_active)
		sensor_fail <= 1'h1;
		cyc(4);
		marginal_power <= 1'h1;
		cyc(3);
		`CHK("fallback aborted", 1'h0, fb_active)
		rchk(`VSRK_A_INT_STAT, 32'hE);
		marginal_power <= 1'h0;
		sensor_fail <= 1'h0;
		for (int i = 0; i < 2; i++) begin
			bus(1'h1, `VSRK_A_CTRL, i ? 32'hC3 : 32'hC5);
			position <= i ? `VSRK_POS_LIM_RST : setpoint - `VSRK_LIM_RST;
			cyc(4);
			`CHK("trigger at limit", 1'h0, fb_active)
			position <= i ? `VSRK_POS_LIM_RST + 16'h1 : setpoint - `VSRK_LIM_RST - 16'h1;
			cyc(4);
			`CHK("trigger beyond limit", 1'h1, fb_active)
			bus(1'h1, `VSRK_A_CTRL, 32'h80);
			position <= setpoint;
			cyc(3);
			`CHK("fallback disabled", 1'h0, fb_active)
		end
		rchk(`VSRK_A_CUR_KPI, 32'h4D2);
		rchk(`VSRK_A_STATE, 32'h0);
		kpi_in <= 16'h012C;
		tick_en <= 1'h1;
		repeat (60) @(posedge clock iff minute_tick);
		tick_en <= 1'h0;
		cyc(3);
		rchk(`VSRK_A_STATE, 32'h400);
		bus(1'h1, `VSRK_A_HIST_SEL, 32'h0);
		rchk(`VSRK_A_HIST_DATA, 32'h12C);
		bus(1'h1, `VSRK_A_ALRT_CFG, 32'h1);
		bus(1'h1, `VSRK_A_ALRT_HI, 32'h12B);
		cyc(2);
		`CHK("alert above range", 1'h1, alert_publish)
		bus(1'h1, `VSRK_A_ALRT_CFG, 32'h3);
		cyc(2);
		`CHK("alert masked", 1'h0, alert_publish)
		bus(1'h1, `VSRK_A_ALRT_HI, 32'hFFFF);
		bus(1'h1, `VSRK_A_ALRT_CFG, 32'h1);
		cyc(2);
		`CHK("alert in range", 1'h0, alert_publish)
		bus(1'h1, `VSRK_A_ALRT_CFG, 32'h0);
		bus(1'h1, `VSRK_A_ALRT_HI, 32'h12B);
		bus(1'h1, `VSRK_A_ALRT_CFG, 32'h1);
		cyc(2);
		`CHK("alert before compare", 1'h0, alert_publish)
		signature_done <= 1'h1;
		cyc(1);
		signature_done <= 1'h0;
		cyc(2);
		`CHK("alert on signature", 1'h1, alert_publish)
		tick_en <= 1'h1;
		repeat (10020) @(posedge clock iff minute_tick);
		tick_en <= 1'h0;
		cyc(3);
		rchk(`VSRK_A_STATE, 32'h40000);
		bus(1'h1, `VSRK_A_HIST_SEL, 32'h46);
		rchk(`VSRK_A_HIST_DATA, 32'h12C);
		bus(1'h1, `VSRK_A_HIST_SEL, 32'h80);
		rchk(`VSRK_A_HIST_DATA, 32'h12C);
		tally_and_finish;
	end
endmodule
